// File: pkg/adr_pkg.sv
// Purpose: constants for the audio dma interrupt and rate control register bank
// Assumes: byte-wide registers in a 128-byte i/o window, 40 MHz system clock
// Notes: crystals are taken as 512 times their family base rate
// Functional notes
// RULE1 - eight sticky status bits, one per dma source, cleared by writing one
// RULE2 - with dma stopped the converters keep seeing the last latched sample
// RULE3 - status bit 3 flags fifo underrun or overrun, cleared by writing one
// RULE4 - mask resets to all ones; a zero mask bit lets that source set status
// RULE5 - mask bits 6, 5, 4 only count once burst size exceeds 00, 01, equals 11
// RULE6 - rate codes 0000 48k, 0001 24k, 0101 16k, 0111 96k, 1111 64k
// RULE7 - rate codes 1000 44.1k, 1001 22.05k, 1010 11.025k from second crystal
// RULE8 - one master clock and one sample rate drive every channel
// RULE9 - rate bit 4 picks external master clock; bit clock still driven out
// RULE10 - rate field is ignored while the external master clock is selected
// RULE11 - external clock is 256fs or 128fs matching ratio bit, passed out 1:1
// RULE12 - internal mode ratio bit gives master clock 256x or 128x the lr clock
// RULE13 - 256fs master clock is never offered above 96 kHz
// RULE14 - bit clock is 64fs and frame sync is fs for either clock source
// RULE15 - data format field 00 selects standard i2s framing, others reserved
// RULE16 - software puts codec in slave mode before selecting external clock
// RULE17 - registers live in a 128-byte i/o window at a configured base
// RULE18 - one interrupt request while any unmasked status bit stays set
package adr_pkg;
    localparam logic [6:0] OFF_STATUS = 7'h00;
    localparam logic [6:0] OFF_RATE = 7'h01;
    localparam logic [6:0] OFF_FORMAT = 7'h02;
    localparam logic [6:0] OFF_MASK = 7'h03;
    localparam int WINDOW_BITS = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] RATE_RESET = 8'h00;
    localparam logic [7:0] FORMAT_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'hff;
    localparam int FIFO_ERR_BIT = 3;
    localparam int EXT_CLK_BIT = 4;
    localparam int RATIO_BIT = 3;
    localparam logic [7:0] RATE_RW_MASK = 8'h1f;
    localparam logic [7:0] FORMAT_RW_MASK = 8'h0f;
    localparam logic [1:0] FMT_I2S = 2'h0;
    localparam logic [1:0] BURST_GT0 = 2'h0;
    localparam logic [1:0] BURST_GT1 = 2'h1;
    localparam logic [1:0] BURST_MAX = 2'h3;
    localparam logic [3:0] RATE_48K = 4'h0;
    localparam logic [3:0] RATE_24K = 4'h1;
    localparam logic [3:0] RATE_16K = 4'h5;
    localparam logic [3:0] RATE_96K = 4'h7;
    localparam logic [3:0] RATE_64K = 4'hf;
    localparam logic [3:0] RATE_44K1 = 4'h8;
    localparam logic [3:0] RATE_22K05 = 4'h9;
    localparam logic [3:0] RATE_11K025 = 4'ha;
    // master clock period at 256x, counted in crystal half periods
    localparam logic [5:0] HP_48K = 6'h04;
    localparam logic [5:0] HP_24K = 6'h08;
    localparam logic [5:0] HP_16K = 6'h0c;
    localparam logic [5:0] HP_96K = 6'h02;
    localparam logic [5:0] HP_64K = 6'h03;
    localparam logic [5:0] HP_11K = 6'h10;
    // bit clock and frame sync taps of the master clock divider
    localparam int BCLK_TAP_256 = 1;
    localparam int LR_TAP_256 = 7;

    typedef struct packed {
        logic use_second;
        logic [5:0] half_periods;
    } adr_rate_t;

    // reserved codes fall back to the default rate so the clocks never stop
    function automatic adr_rate_t rate_lookup(input logic [3:0] code);
        adr_rate_t r;
        r = '{use_second: 1'b0, half_periods: HP_48K};
        case (code)
            RATE_24K: r.half_periods = HP_24K;
            RATE_16K: r.half_periods = HP_16K;
            RATE_96K: r.half_periods = HP_96K;
            RATE_64K: r.half_periods = HP_64K;
            RATE_44K1: r = '{use_second: 1'b1, half_periods: HP_48K};
            RATE_22K05: r = '{use_second: 1'b1, half_periods: HP_24K};
            RATE_11K025: r = '{use_second: 1'b1, half_periods: HP_11K};
            default: r.half_periods = HP_48K;
        endcase
        return r;
    endfunction
endpackage

// File: rtl/adr_ctrl.sv
// Purpose: dma interrupt status/mask, sample rate and serial format registers
// Assumes: crystal and external clock pins are sampled by sys_clk at 40 MHz
// Notes: pin clocks are edge-detected in the system domain, so they must stay slow
`timescale 1ns/1ps
module adr_ctrl
(
    // system
    input wire logic sys_clk,
    input wire logic rst,
    // i/o register port
    input wire logic [15:0] io_base,
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // dma side
    input wire logic [7:0] dma_event,
    input wire logic [1:0] burst_size_field,
    input wire logic dma_run,
    input wire logic sample_load,
    input wire logic [23:0] sample_in,
    output logic [23:0] sample_out,
    output logic irq,
    // clock pins
    input wire logic crystal_48k_in,
    input wire logic crystal_44k_in,
    input wire logic ext_master_clock_in,
    output logic master_clock_out,
    output logic bit_clock_out,
    output logic frame_sync_out,
    output logic format_i2s
);
    logic [7:0] status_reg;
    logic [7:0] rate_reg;
    logic [7:0] format_reg;
    logic [7:0] mask_reg;
    logic [7:0] eff_mask;
    logic [7:0] status_next;
    logic io_hit;
    logic [6:0] io_off;
    logic [2:0] xa_sync;
    logic [2:0] xb_sync;
    logic [2:0] ext_sync;
    logic ext_mode;
    logic ratio_128;
    adr_pkg::adr_rate_t rate_sel;
    logic [5:0] hp_target;
    logic [5:0] hp_cnt;
    logic xtal_edge;
    logic mclk_int;
    logic mclk_rise;
    logic [7:0] div_cnt;

    // i/o window decode
    assign io_hit = (io_addr[15:adr_pkg::WINDOW_BITS] == io_base[15:adr_pkg::WINDOW_BITS]); // RULE17
    assign io_off = io_addr[adr_pkg::WINDOW_BITS-1:0];

    // a mask bit for a pair beyond the burst size is treated as masked
    always_comb
    begin
        eff_mask = mask_reg;
        if (!(burst_size_field > adr_pkg::BURST_GT0))
        begin
            eff_mask[6] = 1'b1; // RULE5
        end
        if (!(burst_size_field > adr_pkg::BURST_GT1))
        begin
            eff_mask[5] = 1'b1; // RULE5
        end
        if (burst_size_field != adr_pkg::BURST_MAX)
        begin
            eff_mask[4] = 1'b1; // RULE5
        end
    end

    // an event in the clearing cycle survives: set is applied after clear
    always_comb
    begin
        status_next = status_reg;
        if (io_hit && io_wr && io_off == adr_pkg::OFF_STATUS)
        begin
            status_next = status_next & ~io_wdata; // RULE1 RULE3
        end
        status_next = status_next | (dma_event & ~eff_mask); // RULE1 RULE3 RULE4
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            status_reg <= adr_pkg::STATUS_RESET;
        end
        else
        begin
            status_reg <= status_next;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            rate_reg <= adr_pkg::RATE_RESET;
            format_reg <= adr_pkg::FORMAT_RESET;
            mask_reg <= adr_pkg::MASK_RESET; // RULE4
        end
        else if (io_hit && io_wr)
        begin
            case (io_off)
                adr_pkg::OFF_RATE: rate_reg <= io_wdata & adr_pkg::RATE_RW_MASK;
                adr_pkg::OFF_FORMAT: format_reg <= io_wdata & adr_pkg::FORMAT_RW_MASK;
                adr_pkg::OFF_MASK: mask_reg <= io_wdata;
                default: mask_reg <= mask_reg;
            endcase
        end
    end

    // read data answers one cycle after the strobe; other offsets read zero
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            io_rdata <= 8'h00;
        end
        else if (io_hit && io_rd)
        begin
            case (io_off)
                adr_pkg::OFF_STATUS: io_rdata <= status_reg;
                adr_pkg::OFF_RATE: io_rdata <= rate_reg;
                adr_pkg::OFF_FORMAT: io_rdata <= format_reg;
                adr_pkg::OFF_MASK: io_rdata <= mask_reg;
                default: io_rdata <= 8'h00; // RULE17
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(status_reg & ~eff_mask); // RULE18
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            format_i2s <= 1'b1;
        end
        else
        begin
            format_i2s <= (format_reg[1:0] == adr_pkg::FMT_I2S); // RULE15
        end
    end

    // a stopped dma leaves the dc value on the converters
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            sample_out <= 24'h000000;
        end
        else if (dma_run && sample_load)
        begin
            sample_out <= sample_in; // RULE2
        end
    end

    // pin synchronisers; bit 2 exists only to detect edges off bit 1
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            xa_sync <= 3'h0;
            xb_sync <= 3'h0;
            ext_sync <= 3'h0;
        end
        else
        begin
            xa_sync <= {xa_sync[1:0], crystal_48k_in};
            xb_sync <= {xb_sync[1:0], crystal_44k_in};
            ext_sync <= {ext_sync[1:0], ext_master_clock_in};
        end
    end

    assign ext_mode = rate_reg[adr_pkg::EXT_CLK_BIT]; // RULE9
    assign ratio_128 = format_reg[adr_pkg::RATIO_BIT]; // RULE11 RULE12
    assign rate_sel = adr_pkg::rate_lookup(rate_reg[3:0]); // RULE6 RULE7 RULE10
    // the 256x table never runs the master clock faster than the crystal
    assign hp_target = ratio_128 ? {rate_sel.half_periods[4:0], 1'b0}
                                 : rate_sel.half_periods; // RULE12 RULE13
    assign xtal_edge = rate_sel.use_second ? (xb_sync[2] ^ xb_sync[1])
                                           : (xa_sync[2] ^ xa_sync[1]); // RULE7

    // one master clock source feeds every divider, so all channels share fs
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            hp_cnt <= 6'h00;
        end
        else if (ext_mode)
        begin
            hp_cnt <= 6'h00; // RULE10
        end
        else if (xtal_edge)
        begin
            if (hp_cnt >= hp_target - 6'h01)
            begin
                hp_cnt <= 6'h00; // RULE8
            end
            else
            begin
                hp_cnt <= hp_cnt + 6'h01;
            end
        end
    end

    always_comb
    begin
        if (ext_mode)
        begin
            mclk_int = ext_sync[1]; // RULE11
            mclk_rise = ext_sync[1] & ~ext_sync[2];
        end
        else
        begin
            mclk_int = ({hp_cnt, 1'b0} < hp_target);
            mclk_rise = xtal_edge && (hp_cnt >= hp_target - 6'h01);
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            div_cnt <= 8'h00;
            master_clock_out <= 1'b0;
        end
        else
        begin
            master_clock_out <= mclk_int; // RULE11 RULE12
            if (mclk_rise)
            begin
                div_cnt <= div_cnt + 8'h01; // RULE8
            end
        end
    end

    // bit clock is still driven out while slaved to the external clock
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            bit_clock_out <= 1'b0;
            frame_sync_out <= 1'b0;
        end
        else if (ratio_128)
        begin
            bit_clock_out <= div_cnt[adr_pkg::BCLK_TAP_256-1]; // RULE9 RULE14
            frame_sync_out <= div_cnt[adr_pkg::LR_TAP_256-1]; // RULE14
        end
        else
        begin
            bit_clock_out <= div_cnt[adr_pkg::BCLK_TAP_256]; // RULE9 RULE14
            frame_sync_out <= div_cnt[adr_pkg::LR_TAP_256]; // RULE14
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    logic st_wr;
    assign st_wr = io_hit && io_wr && io_off == adr_pkg::OFF_STATUS;

    w1c_clear_a: assert property ( // RULE1
        st_wr && io_wdata[0] && !dma_event[0] |=> !status_reg[0])
        else $error("status bit not cleared by write one");
    set_wins_a: assert property ( // RULE1
        st_wr && io_wdata[7] && dma_event[7] && !eff_mask[7] |=> status_reg[7])
        else $error("event lost in clearing cycle");
    status_sticky_a: assert property ( // RULE1
        status_reg[1] && !(st_wr && io_wdata[1]) |=> status_reg[1])
        else $error("status bit dropped without a clear");
    // a clear written in the cycle after the event may legally end the hold
    fifo_err_a: assert property ( // RULE3
        dma_event[adr_pkg::FIFO_ERR_BIT] && !mask_reg[3] |=> status_reg[adr_pkg::FIFO_ERR_BIT]
        ##1 (status_reg[adr_pkg::FIFO_ERR_BIT] || $past(st_wr && io_wdata[3])))
        else $error("fifo error flag not held");
    masked_src_a: assert property ( // RULE4
        dma_event[2] && mask_reg[2] && !status_reg[2] |=> !status_reg[2])
        else $error("masked source set status");
    mask_read_a: assert property ( // RULE4
        io_hit && io_rd && io_off == adr_pkg::OFF_MASK |=> io_rdata == $past(mask_reg))
        else $error("mask register read back wrong");
    burst_gate_a: assert property ( // RULE5
        burst_size_field == 2'h0 && dma_event[6] && !status_reg[6] |=> !status_reg[6])
        else $error("invalid mask bit let pair through");
    irq_level_a: assert property ( // RULE18
        ##1 irq == $past(|(status_reg & ~eff_mask)))
        else $error("interrupt does not follow unmasked status");
    irq_drop_a: assert property ( // RULE18
        (status_reg & ~eff_mask) == 8'h00 |=> !irq)
        else $error("interrupt held with no unmasked status");
    sample_hold_a: assert property ( // RULE2
        !dma_run |=> $stable(sample_out))
        else $error("sample changed while dma stopped");
    sample_load_a: assert property ( // RULE2
        dma_run && sample_load |=> sample_out == $past(sample_in))
        else $error("running dma did not latch the sample");
    reserved_ro_a: assert property ( // RULE15
        rate_reg[7:5] == 3'h0 && format_reg[7:4] == 4'h0)
        else $error("reserved register bits became set");
    ext_hold_a: assert property ( // RULE10
        ext_mode |=> hp_cnt == 6'h00)
        else $error("internal divider ran in external clock mode");
    ext_pass_a: assert property ( // RULE11
        ext_mode [*4] |-> master_clock_out == $past(ext_master_clock_in, 3))
        else $error("external master clock not passed one to one");
    mclk_cap_a: assert property ( // RULE13
        !ext_mode && !ratio_128 |-> hp_target >= 6'h02)
        else $error("256x master clock faster than the crystal");
    // a ratio change swaps divider taps, which may move frame sync by itself
    sync_from_mclk_a: assert property ( // RULE14
        $changed(frame_sync_out) && $past(ratio_128, 2) == $past(ratio_128)
        |-> $past(mclk_rise, 2))
        else $error("frame sync moved without master clock");
    unmapped_read_a: assert property ( // RULE17
        io_hit && io_rd && io_off > adr_pkg::OFF_MASK |=> io_rdata == 8'h00)
        else $error("unmapped offset read nonzero");

    clear_seen_c: cover property (status_reg[0] ##1 st_wr && io_wdata[0] ##1 !status_reg[0]);
    irq_rise_c: cover property (!irq ##1 irq);
    ext_mode_c: cover property (ext_mode && mclk_rise);
    sync_toggle_c: cover property ($rose(frame_sync_out));
    fifo_err_c: cover property (dma_event[adr_pkg::FIFO_ERR_BIT] && !eff_mask[3]);
endmodule // adr_ctrl

// File: tb/adr_clk_partner.sv
// Purpose: crystal and external master clock sources facing adr_ctrl
// Assumes: half periods in ns, well below the 40 MHz sampling rate
// Notes: sources run free like real oscillators, phases offset on purpose
`timescale 1ns/1ps
module adr_clk_partner
#(
    parameter int XTAL_A_HALF = 41,
    parameter int XTAL_B_HALF = 45,
    parameter int EXT_HALF = 47
)
(
    // crystal pins
    output logic crystal_48k_in,
    output logic crystal_44k_in,
    // external master clock, used as 256fs or 128fs
    output logic ext_master_clock_in
);
    initial
    begin
        crystal_48k_in = 1'b0;
        forever #(XTAL_A_HALF) crystal_48k_in = ~crystal_48k_in;
    end
    initial
    begin
        crystal_44k_in = 1'b1;
        forever #(XTAL_B_HALF) crystal_44k_in = ~crystal_44k_in;
    end
    initial
    begin
        ext_master_clock_in = 1'b0;
        #7;
        forever #(EXT_HALF) ext_master_clock_in = ~ext_master_clock_in;
    end
endmodule // adr_clk_partner

// File: tb/testbench.sv
// Purpose: self-checking bench for adr_ctrl registers and clock outputs
// Assumes: one-cycle io strobes, pin clocks from adr_clk_partner
// Notes: clock checks span whole frames and dominate the run time
`timescale 1ns/1ps
module testbench;
    localparam logic [15:0] BASE = 16'h0380;
    localparam int XA = 41;
    localparam int XB = 45;
    localparam int XE = 47;
    logic sys_clk, rst, io_wr, io_rd, dma_run, sample_load, format_i2s, irq;
    logic [15:0] io_base, io_addr;
    logic [7:0] io_wdata, io_rdata, dma_event;
    logic [1:0] burst_size_field;
    logic [23:0] sample_in, sample_out;
    logic crystal_48k_in, crystal_44k_in, ext_master_clock_in;
    logic master_clock_out, bit_clock_out, frame_sync_out;
    int n_fail, check_count, per, nm, nb;
    logic [7:0] b_exp [4] = '{8'h00, 8'h40, 8'h60, 8'h70};
    // rate byte and frame length in ns per clock setup
    logic [7:0] c_rate [12] = '{8'h00, 8'h01, 8'h05, 8'h07, 8'h0f, 8'h08, 8'h09,
        8'h0a, 8'h00, 8'h10, 8'h1a, 8'h10};
    int c_per [12] = '{1024 * XA, 2048 * XA, 3072 * XA, 512 * XA, 768 * XA, 1024 * XB,
        2048 * XB, 4096 * XB, 1024 * XA, 512 * XE, 512 * XE, 256 * XE};
    adr_ctrl dut
    (
        .sys_clk, .rst, .io_base, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata,
        .dma_event, .burst_size_field, .dma_run, .sample_load, .sample_in, .sample_out,
        .irq, .crystal_48k_in, .crystal_44k_in, .ext_master_clock_in, .master_clock_out,
        .bit_clock_out, .frame_sync_out, .format_i2s
    );
    adr_clk_partner #(.XTAL_A_HALF(XA), .XTAL_B_HALF(XB), .EXT_HALF(XE)) partner
    (
        .crystal_48k_in, .crystal_44k_in, .ext_master_clock_in
    );
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic give_verdict();
        if (n_fail == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic cmp_v(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_n(input int got, input int exp, input int tol);
        check_count++;
        if (got > exp + tol || got < exp - tol)
        begin
            n_fail++;
            $display("ERROR %0t count %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        step(1);
        io_wr = 1'b0;
        step(1);
    endtask
    task automatic reg_rd(input logic [15:0] a, input logic [7:0] exp);
        io_addr = a;
        io_rd = 1'b1;
        step(1);
        io_rd = 1'b0;
        cmp_v(24'(io_rdata), 24'(exp));
        step(1);
    endtask
    task automatic pulse(input logic [7:0] ev);
        dma_event = ev;
        step(1);
        dma_event = 8'h00;
        step(2);
    endtask
    // counts over the second whole frame, the first may still carry the old setup
    task automatic measure();
        int edges;
        int guard;
        logic pm, pb, pf;
        realtime ts;
        edges = 0;
        guard = 0;
        ts = 0;
        pm = master_clock_out;
        pb = bit_clock_out;
        pf = frame_sync_out;
        while (edges < 3 && guard < 30000)
        begin
            step(1);
            guard++;
            nm += int'(master_clock_out && !pm);
            nb += int'(bit_clock_out && !pb);
            if (frame_sync_out && !pf)
                edges++;
            if (frame_sync_out && !pf && edges == 2)
            begin
                ts = $realtime;
                nm = 0;
                nb = 0;
            end
            pm = master_clock_out;
            pb = bit_clock_out;
            pf = frame_sync_out;
        end
        per = int'($realtime - ts);
        if (edges < 3)
        begin
            n_fail++;
            $display("ERROR %0t clock outputs stalled", $time);
            give_verdict();
        end
    endtask
    initial
    begin
        rst = 1'b1;
        io_base = BASE;
        io_addr = 16'h0000;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
        dma_event = 8'h00;
        burst_size_field = 2'h3;
        dma_run = 1'b0;
        sample_load = 1'b0;
        sample_in = 24'h000000;
        n_fail = 0;
        check_count = 0;
        step(3);
        rst = 1'b0;
        reg_rd(BASE, 8'h00);
        reg_rd(BASE + 16'h1, 8'h00);
        reg_rd(BASE + 16'h2, 8'h00);
        reg_rd(BASE + 16'h3, 8'hff);
        cmp_v(24'(format_i2s), 24'h1);
        reg_wr(BASE + 16'h1, 8'hef);
        reg_rd(BASE + 16'h1, 8'h0f);
        reg_wr(BASE + 16'h2, 8'hf5);
        reg_rd(BASE + 16'h2, 8'h05);
        cmp_v(24'(format_i2s), 24'h0);
        reg_wr(BASE + 16'h7f, 8'h5a);
        reg_rd(BASE + 16'h7f, 8'h00);
        reg_wr(16'h0303, 8'h00);
        reg_rd(BASE + 16'h3, 8'hff);
        pulse(8'hff);
        reg_rd(BASE, 8'h00);
        reg_wr(BASE + 16'h3, 8'h00);
        pulse(8'hff);
        reg_rd(BASE, 8'hff);
        cmp_v(24'(irq), 24'h1);
        reg_wr(BASE, 8'h08);
        reg_rd(BASE, 8'hf7);
        reg_wr(BASE, 8'hf7);
        reg_rd(BASE, 8'h00);
        cmp_v(24'(irq), 24'h0);
        for (int b = 0; b < 4; b++)
        begin
            burst_size_field = 2'(b);
            pulse(8'h70);
            reg_rd(BASE, b_exp[b]);
            reg_wr(BASE, 8'hff);
        end
        reg_wr(BASE + 16'h3, 8'hfe);
        pulse(8'h81);
        reg_rd(BASE, 8'h01);
        cmp_v(24'(irq), 24'h1);
        dma_run = 1'b1;
        sample_in = 24'hc3a55a;
        sample_load = 1'b1;
        step(1);
        dma_run = 1'b0;
        sample_in = 24'h3c5aa5;
        step(1);
        cmp_v(sample_out, 24'hc3a55a);
        sample_load = 1'b0;
        step(1);
        cmp_v(sample_out, 24'hc3a55a);
        // no codec link here, so the external clock needs no codec handover first
        for (int i = 0; i < 12; i++)
        begin
            reg_wr(BASE + 16'h2, (i == 8 || i == 11) ? 8'h08 : 8'h00);
            reg_wr(BASE + 16'h1, c_rate[i]);
            measure();
            cmp_n(per, c_per[i], 60);
            cmp_n(nm, (i == 8 || i == 11) ? 128 : 256, 0);
            cmp_n(nb, 64, 0);
        end
        give_verdict();
    end
endmodule // testbench
